// *** include/cds_defines.svh ***
// constants for the channel, drive and disconnect sense register group
// assumes a 40 MHz system clock and an AXI4-Lite master with 8-bit addresses
`ifndef CDS_DEFINES_SVH
`define CDS_DEFINES_SVH
// register indices, byte address is four times the index
`define CDS_IDX_CH2      6'h05
`define CDS_IDX_DRV      6'h06
`define CDS_IDX_LOFF     6'h07
`define CDS_IDX_CFG      6'h10
`define CDS_IDX_STAT     6'h11
// field positions
`define CDS_PD_BIT       7
`define CDS_GAIN_HI      6
`define CDS_GAIN_LO      4
`define CDS_SRC_HI       3
`define CDS_SRC_LO       0
`define CDS_CHOP_HI      7
`define CDS_CHOP_LO      6
`define CDS_BUF_BIT      5
`define CDS_DSENSE_BIT   4
`define CDS_SECOND_CURRENT_DIRECTION_BIT    5
`define CDS_FIRST_CURRENT_DIRECTION_BIT    4
`define CDS_IN2N_BIT     3
`define CDS_IN2P_BIT     2
`define CDS_IN1N_BIT     1
`define CDS_IN1P_BIT     0
`define CDS_CLKDIV_BIT   0
`define CDS_LOFF_MASK    8'h3f
`define CDS_CFG_MASK     8'h01
// reset values
`define CDS_CH2_RST      8'h00
`define CDS_DRV_RST      8'h00
`define CDS_LOFF_RST     8'h00
`define CDS_CFG_RST      8'h00
// source codes
`define CDS_SRC_SHORT    4'h1
`define CDS_SRC_RSV_MIN  4'ha
// gain codes and gain values
`define CDS_GC_6         3'h0
`define CDS_GC_1         3'h1
`define CDS_GC_2         3'h2
`define CDS_GC_3         3'h3
`define CDS_GC_4         3'h4
`define CDS_GC_8         3'h5
`define CDS_GC_12        3'h6
`define CDS_GV_6         4'h6
`define CDS_GV_1         4'h1
`define CDS_GV_2         4'h2
`define CDS_GV_3         4'h3
`define CDS_GV_4         4'h4
`define CDS_GV_8         4'h8
`define CDS_GV_12        4'hc
`define CDS_GV_NONE      4'h0
// chop codes and division terminal counts (divisor minus one)
`define CDS_CHOP_16      2'h0
`define CDS_CHOP_RSV     2'h1
`define CDS_CHOP_2       2'h2
`define CDS_CHOP_4       2'h3
`define CDS_LIM_16       4'hf
`define CDS_LIM_2        4'h1
`define CDS_LIM_4        4'h3
// modulator division terminal counts: input clock over 4 or 16
`define CDS_MOD_LIM_4    4'h3
`define CDS_MOD_LIM_16   4'hf
// bus responses
`define CDS_RESP_OKAY    2'h0
`define CDS_RESP_SLVERR  2'h2
`endif

// *** include/cds_pkg.sv ***
// types for the channel, drive and disconnect sense register group
// assumes cds_defines.svh supplies the numeric constants
package cds_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [3:0] gain_val_t;
  typedef logic [3:0] count_t;
endpackage

// *** rtl/cds_gain_decode.sv ***
// decode of the second channel gain and source codes
// assumes codes come straight from the settings register
`timescale 1ns/100ps
`default_nettype none
`include "cds_defines.svh"
module cds_gain_decode
  import cds_pkg::*;
(
  // codes in
  input  wire logic [2:0] gain_code,
  input  wire logic [3:0] source_code,
  // decoded
  output gain_val_t       gain_value,
  output logic            source_reserved
);
  assign gain_value = (gain_code == `CDS_GC_6)  ? `CDS_GV_6  :
                      (gain_code == `CDS_GC_1)  ? `CDS_GV_1  :
                      (gain_code == `CDS_GC_2)  ? `CDS_GV_2  :
                      (gain_code == `CDS_GC_3)  ? `CDS_GV_3  :
                      (gain_code == `CDS_GC_4)  ? `CDS_GV_4  :
                      (gain_code == `CDS_GC_8)  ? `CDS_GV_8  :
                      (gain_code == `CDS_GC_12) ? `CDS_GV_12 : `CDS_GV_NONE;
  assign source_reserved = (source_code >= `CDS_SRC_RSV_MIN);
endmodule
`default_nettype wire

// *** rtl/cds_chop_div.sv ***
// modulator clock and amplifier chop tick generation
// assumes one system clock; ticks are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "cds_defines.svh"
module cds_chop_div
  import cds_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // configuration
  input  wire logic       clk_div_sel,
  input  wire logic [1:0] chop_code,
  // ticks
  output logic            mod_tick_q,
  output logic            chop_tick_q
);
  count_t mod_cnt_q;
  count_t chop_cnt_q;
  wire count_t mod_lim  = clk_div_sel ? `CDS_MOD_LIM_16 : `CDS_MOD_LIM_4;
  wire count_t chop_lim = (chop_code == `CDS_CHOP_2) ? `CDS_LIM_2 :
                          (chop_code == `CDS_CHOP_4) ? `CDS_LIM_4 : `CDS_LIM_16;
  wire logic   mod_wrap  = (mod_cnt_q >= mod_lim);
  wire logic   chop_wrap = mod_wrap && (chop_cnt_q >= chop_lim);
  // reserved chop code stops the chop ticks
  wire logic   chop_run  = (chop_code != `CDS_CHOP_RSV);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mod_cnt_q   <= '0;
      chop_cnt_q  <= '0;
      mod_tick_q  <= 1'b0;
      chop_tick_q <= 1'b0;
    end else begin
      mod_cnt_q   <= mod_wrap ? '0 : mod_cnt_q + 4'h1;
      chop_cnt_q  <= chop_wrap ? '0 : (mod_wrap ? chop_cnt_q + 4'h1 : chop_cnt_q);
      mod_tick_q  <= mod_wrap;
      chop_tick_q <= chop_wrap && chop_run;
    end
  end
endmodule
`default_nettype wire

// *** rtl/cds_regs.sv ***
// register group for second channel, drive derivation and disconnect sensing
// assumes an AXI4-Lite master with one write and one read outstanding at most
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cds_defines.svh"
// Summary of operation
// - settings register at 05h: powerdown bit7, gain 6:4, source 3:0
// - powerdown resets to 0, normal; 1 powers the second channel down
// - gain codes 000..110 give 6,1,2,3,4,8,12; 000 is default
// - source codes 0000..1001 select inputs; 1010 and up are reserved
// - drive register at 06h: chop 7:6, buffer 5, sense 4, routing 3:0
// - chop code 00 divides by 16, 10 by 2, 11 by 4; 01 reserved
// - drive buffer power resets to 0, off; 1 enables the buffer
// - drive disconnect sense resets to 0, off; 1 enables sensing
// - bits 3 and 2 route second negative and positive into drive
// - bits 1 and 0 route first negative and positive into drive
// - disconnect register at 07h: bits 7:6 zero, flips 5:4, enables 3:0
// - current direction flags reset to 0; 1 reverses the excitation current
// - four sense enables reset to 0; 1 includes that input in detection
// - modulator clock is input clock over 4, or over 16 when selected
module cds_regs
  import cds_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // second channel controls
  output logic             second_channel_powerdown,
  output logic [2:0]       second_channel_gain_code,
  output logic [3:0]       second_channel_source_code,
  output logic [3:0]       second_channel_gain_value,
  // drive controls
  output logic             drive_buffer_power,
  output logic             drive_disconnect_sense_enable,
  output logic             drive_from_second_negative,
  output logic             drive_from_second_positive,
  output logic             drive_from_first_negative,
  output logic             drive_from_first_positive,
  // disconnect sense controls
  output logic             second_current_direction,
  output logic             first_current_direction,
  output logic             sense_second_negative,
  output logic             sense_second_positive,
  output logic             sense_first_negative,
  output logic             sense_first_positive,
  // timing
  output logic             clock_div_select,
  output logic             modulator_tick,
  output logic             chop_tick
);
  // register state
  reg8_t       ch2_q;
  reg8_t       drv_q;
  reg8_t       loff_q;
  reg8_t       cfg_q;
  gain_val_t   gain_value_q;
  logic        src_rsv_q;
  // write channel state
  logic        aw_full_q;
  logic        w_full_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [7:0]  waddr_q;
  reg8_t       wd_q;
  logic        wstrb0_q;
  // read channel state
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // write handshakes: address and data accepted in either order
  wire logic aw_take   = awvalid && awready_q;
  wire logic w_take    = wvalid && wready_q;
  wire logic wr_fire   = aw_full_q && w_full_q && !bvalid_q;
  wire logic aw_full_d = !wr_fire && (aw_full_q || aw_take);
  wire logic w_full_d  = !wr_fire && (w_full_q || w_take);
  wire logic bvalid_d  = wr_fire || (bvalid_q && !bready);

  // write decode
  wire logic [5:0] widx     = waddr_q[7:2];
  wire logic       w_ch2    = (widx == `CDS_IDX_CH2);
  wire logic       w_drv    = (widx == `CDS_IDX_DRV);
  wire logic       w_loff   = (widx == `CDS_IDX_LOFF);
  wire logic       w_cfg    = (widx == `CDS_IDX_CFG);
  wire logic       w_stat   = (widx == `CDS_IDX_STAT);
  wire logic       w_mapped = w_ch2 || w_drv || w_loff || w_cfg || w_stat;
  wire logic       w_lane   = wr_fire && wstrb0_q;
  wire logic [1:0] wresp    = w_mapped ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;

  // read handshakes and decode
  wire logic       ar_take   = arvalid && arready_q;
  wire logic       rd_busy_d = ar_take || (rvalid_q && !rready);
  wire logic [5:0] ridx      = araddr[7:2];

  // decoded codes and status
  gain_val_t gain_value_d;
  logic      src_rsv_d;
  logic      mod_tick_w;
  logic      chop_tick_w;
  wire logic chop_rsv  = (drv_q[`CDS_CHOP_HI:`CDS_CHOP_LO] == `CDS_CHOP_RSV);
  // powered down while input not shorted
  wire logic pd_unsafe = ch2_q[`CDS_PD_BIT] &&
                         (ch2_q[`CDS_SRC_HI:`CDS_SRC_LO] != `CDS_SRC_SHORT);
  wire logic [31:0] stat_word = {24'h0, pd_unsafe, chop_tick_w, chop_rsv, src_rsv_q,
                                 gain_value_q};

  wire logic [31:0] rd_mux =
    (ridx == `CDS_IDX_CH2)  ? {24'h0, ch2_q}  :
    (ridx == `CDS_IDX_DRV)  ? {24'h0, drv_q}  :
    (ridx == `CDS_IDX_LOFF) ? {24'h0, loff_q} :
    (ridx == `CDS_IDX_CFG)  ? {24'h0, cfg_q}  :
    (ridx == `CDS_IDX_STAT) ? stat_word       : 32'h0;
  wire logic r_mapped = (ridx == `CDS_IDX_CH2) || (ridx == `CDS_IDX_DRV) ||
                        (ridx == `CDS_IDX_LOFF) || (ridx == `CDS_IDX_CFG) ||
                        (ridx == `CDS_IDX_STAT);
  wire logic [1:0] rresp_d = r_mapped ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;

  cds_gain_decode u_decode (
    .gain_code       (ch2_q[`CDS_GAIN_HI:`CDS_GAIN_LO]),
    .source_code     (ch2_q[`CDS_SRC_HI:`CDS_SRC_LO]),
    .gain_value      (gain_value_d),
    .source_reserved (src_rsv_d)
  );

  cds_chop_div u_chop (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_div_sel (cfg_q[`CDS_CLKDIV_BIT]),
    .chop_code   (drv_q[`CDS_CHOP_HI:`CDS_CHOP_LO]),
    .mod_tick_q  (mod_tick_w),
    .chop_tick_q (chop_tick_w)
  );

  // write channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CDS_RESP_OKAY;
      waddr_q   <= 8'h00;
      wd_q      <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q  <= !w_full_d;
      bvalid_q  <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wresp;
      end
      if (aw_take) begin
        waddr_q <= awaddr;
      end
      if (w_take) begin
        wd_q     <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
    end
  end

  // configuration registers, defaults all zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch2_q  <= `CDS_CH2_RST;
      drv_q  <= `CDS_DRV_RST;
      loff_q <= `CDS_LOFF_RST;
      cfg_q  <= `CDS_CFG_RST;
    end else begin
      if (w_lane && w_ch2) begin
        ch2_q <= wd_q;
      end
      if (w_lane && w_drv) begin
        drv_q <= wd_q;
      end
      if (w_lane && w_loff) begin
        loff_q <= wd_q & `CDS_LOFF_MASK;
      end
      if (w_lane && w_cfg) begin
        cfg_q <= wd_q & `CDS_CFG_MASK;
      end
    end
  end

  // decoded state and read channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_value_q <= `CDS_GV_6;
      src_rsv_q    <= 1'b0;
      arready_q    <= 1'b0;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h0;
      rresp_q      <= `CDS_RESP_OKAY;
    end else begin
      gain_value_q <= gain_value_d;
      src_rsv_q    <= src_rsv_d;
      arready_q    <= !rd_busy_d;
      rvalid_q     <= rd_busy_d;
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= rresp_d;
      end
    end
  end

  // outputs straight from register bits
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign second_channel_powerdown      = ch2_q[`CDS_PD_BIT];
  assign second_channel_gain_code      = ch2_q[`CDS_GAIN_HI:`CDS_GAIN_LO];
  assign second_channel_source_code    = ch2_q[`CDS_SRC_HI:`CDS_SRC_LO];
  assign second_channel_gain_value     = gain_value_q;
  assign drive_buffer_power            = drv_q[`CDS_BUF_BIT];
  assign drive_disconnect_sense_enable = drv_q[`CDS_DSENSE_BIT];
  assign drive_from_second_negative    = drv_q[`CDS_IN2N_BIT];
  assign drive_from_second_positive    = drv_q[`CDS_IN2P_BIT];
  assign drive_from_first_negative     = drv_q[`CDS_IN1N_BIT];
  assign drive_from_first_positive     = drv_q[`CDS_IN1P_BIT];
  assign second_current_direction      = loff_q[`CDS_SECOND_CURRENT_DIRECTION_BIT];
  assign first_current_direction       = loff_q[`CDS_FIRST_CURRENT_DIRECTION_BIT];
  assign sense_second_negative         = loff_q[`CDS_IN2N_BIT];
  assign sense_second_positive         = loff_q[`CDS_IN2P_BIT];
  assign sense_first_negative          = loff_q[`CDS_IN1N_BIT];
  assign sense_first_positive          = loff_q[`CDS_IN1P_BIT];
  assign clock_div_select              = cfg_q[`CDS_CLKDIV_BIT];
  assign modulator_tick                = mod_tick_w;
  assign chop_tick                     = chop_tick_w;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ch2_write: assert property (
    (wr_fire && wstrb0_q && w_ch2) |=> (ch2_q == $past(wd_q)))
    else $error("settings register did not take written byte");

  a_reset_dflt: assert property (
    $past(sys_rst) |-> (ch2_q == `CDS_CH2_RST && drv_q == `CDS_DRV_RST &&
                        loff_q == `CDS_LOFF_RST && !second_channel_powerdown))
    else $error("register defaults wrong after reset");

  a_gain_map: assert property (
    (second_channel_gain_code == `CDS_GC_8) [*2] |-> (gain_value_q == `CDS_GV_8))
    else $error("gain code 101 did not give gain 8");

  a_src_rsv: assert property (
    (second_channel_source_code >= `CDS_SRC_RSV_MIN) [*2] |-> src_rsv_q)
    else $error("reserved source code not flagged");

  a_pd_unsafe: assert property (
    (second_channel_powerdown && second_channel_source_code == `CDS_SRC_SHORT)
      |-> !stat_word[7])
    else $error("shorted input flagged unsafe at powerdown");

  a_drive_write: assert property (
    (wr_fire && wstrb0_q && w_drv) |=>
      (drive_buffer_power == $past(wd_q[`CDS_BUF_BIT]) &&
       drive_from_first_positive == $past(wd_q[`CDS_IN1P_BIT])))
    else $error("drive register fields did not follow write");

  a_chop_div2: assert property (
    disable iff (sys_rst || wr_fire)
    (chop_tick && drv_q[`CDS_CHOP_HI:`CDS_CHOP_LO] == `CDS_CHOP_2 && !clock_div_select)
      |=> (!chop_tick) [*7] ##1 chop_tick)
    else $error("chop period at code 10 is not eight clocks");

  a_fixed_zero: assert property (
    (wr_fire && wstrb0_q && w_loff) |=> (loff_q[7:6] == 2'h0 &&
      loff_q[5:0] == $past(wd_q[5:0])))
    else $error("disconnect register fixed bits not zero");

  a_mod_div4: assert property (
    disable iff (sys_rst || wr_fire)
    (modulator_tick && !clock_div_select) |=> (!modulator_tick) [*3] ##1 modulator_tick)
    else $error("modulator period is not four clocks");

  a_resp_after: assert property (
    $rose(bvalid_q) |-> ($past(aw_full_q) && $past(w_full_q)))
    else $error("write response before address and data");

  a_pd_flag: assert property (
    (second_channel_powerdown && second_channel_source_code != `CDS_SRC_SHORT) |-> stat_word[7])
    else $error("powerdown without shorted input not flagged");

  a_src_clear: assert property (
    (second_channel_source_code < `CDS_SRC_RSV_MIN) [*2] |-> !src_rsv_q)
    else $error("valid source code flagged reserved");

  a_gain_dflt: assert property (
    (second_channel_gain_code == `CDS_GC_6) [*2] |-> (gain_value_q == `CDS_GV_6))
    else $error("gain code 000 did not give gain 6");

  a_chop_stop: assert property (
    (drv_q[`CDS_CHOP_HI:`CDS_CHOP_LO] == `CDS_CHOP_RSV) [*2] |-> !chop_tick)
    else $error("reserved chop code still ticks");

  a_ch2_read: assert property (
    (ar_take && ridx == `CDS_IDX_CH2) |=> (rvalid_q && rdata_q == {24'h0, $past(ch2_q)}))
    else $error("settings register read wrong");

  a_cfg_write: assert property (
    (wr_fire && wstrb0_q && w_cfg) |=> (clock_div_select == $past(wd_q[`CDS_CLKDIV_BIT])))
    else $error("clock divider select did not follow write");

  c_src_rsv: cover property (src_rsv_q && second_channel_powerdown);
  c_ch2_write: cover property (wr_fire && w_ch2 && wstrb0_q);
  c_stat_read: cover property (ar_take && ridx == `CDS_IDX_STAT ##1 rvalid_q);
  c_chop4: cover property (chop_tick && drv_q[`CDS_CHOP_HI:`CDS_CHOP_LO] == `CDS_CHOP_4);
  c_unmapped: cover property (bvalid_q && bresp_q == `CDS_RESP_SLVERR);
endmodule
`default_nettype wire

// *** sim/cds_regs_tb.sv ***
// self-checking bench for the channel, drive and disconnect sense register group
// assumes cds_regs alone, driven by an axi4-lite master built from bench tasks
`timescale 1ns/100ps
`default_nettype none
`include "cds_defines.svh"
module cds_regs_tb
  import cds_pkg::*;
();
  // clock, reset and bus
  logic        clk;
  logic        sys_rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  // block controls
  logic        pd2;
  logic [2:0]  gain_code;
  logic [3:0]  src_code;
  logic [3:0]  gain_value;
  wire logic [5:0] drive_bits;
  wire logic [5:0] disc_bits;
  logic        div_sel;
  logic        modulator_tick;
  logic        chop_tick;
  int          num_errors;
  int          checks_done;
  localparam logic [7:0] A_CH2  = {`CDS_IDX_CH2, 2'b00};
  localparam logic [7:0] A_DRV  = {`CDS_IDX_DRV, 2'b00};
  localparam logic [7:0] A_DISC = {`CDS_IDX_LOFF, 2'b00};
  localparam logic [7:0] A_CFG  = {`CDS_IDX_CFG, 2'b00};
  localparam logic [7:0] A_STAT = {`CDS_IDX_STAT, 2'b00};

  cds_regs cds_regs_i (
    .clk(clk), .sys_rst(sys_rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .second_channel_powerdown(pd2), .second_channel_gain_code(gain_code),
    .second_channel_source_code(src_code), .second_channel_gain_value(gain_value),
    .drive_buffer_power(drive_bits[5]), .drive_disconnect_sense_enable(drive_bits[4]),
    .drive_from_second_negative(drive_bits[3]), .drive_from_second_positive(drive_bits[2]),
    .drive_from_first_negative(drive_bits[1]), .drive_from_first_positive(drive_bits[0]),
    .second_current_direction(disc_bits[5]), .first_current_direction(disc_bits[4]),
    .sense_second_negative(disc_bits[3]), .sense_second_positive(disc_bits[2]),
    .sense_first_negative(disc_bits[1]), .sense_first_positive(disc_bits[0]),
    .clock_div_select(div_sel), .modulator_tick(modulator_tick), .chop_tick(chop_tick)
  );

  always #12.5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    chk("bvalid", {31'h0, bvalid}, 32'h1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rdata", rdata, {24'h0, d});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // cycles between the second and third pulse of a tick output
  task automatic tick_gap(input bit use_chop, output int gap);
    int n;
    int seen;
    n = 0;
    seen = 0;
    gap = 0;
    while (seen < 3 && n < 3000) begin
      @(posedge clk);
      n++;
      gap++;
      if ((use_chop ? chop_tick : modulator_tick) === 1'b1) begin
        seen++;
        if (seen < 3) gap = 0;
      end
    end
  endtask

  task automatic t_defaults();
    chk("ch2 out", {pd2, gain_code, src_code}, 32'h0);
    chk("gain value", gain_value, 32'h6);
    chk("drive out", drive_bits, 32'h0);
    chk("disc out", disc_bits, 32'h0);
    rd_chk(A_CH2, 8'h00, `CDS_RESP_OKAY);
    rd_chk(A_DRV, 8'h00, `CDS_RESP_OKAY);
    rd_chk(A_DISC, 8'h00, `CDS_RESP_OKAY);
    rd_chk(A_CFG, 8'h00, `CDS_RESP_OKAY);
  endtask

  task automatic t_settings();
    logic [3:0] gexp [7];
    gexp = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc};
    for (int g = 0; g < 7; g++) begin
      axi_write(A_CH2, {1'b0, g[2:0], 4'h0}, 4'h1, `CDS_RESP_OKAY);
      chk("gain code", gain_code, g);
      chk("gain value", gain_value, gexp[g]);
    end
    for (int s = 0; s < 10; s++) begin
      axi_write(A_CH2, {4'h0, s[3:0]}, 4'h1, `CDS_RESP_OKAY);
      chk("source code", src_code, s);
    end
    // powerdown issued together with the shorted-input source
    axi_write(A_CH2, 8'hd1, 4'h1, `CDS_RESP_OKAY);
    chk("powerdown", {pd2, gain_code, src_code}, 32'hd1);
    rd_chk(A_CH2, 8'hd1, `CDS_RESP_OKAY);
  endtask

  task automatic t_walk();
    for (int i = 0; i < 6; i++) begin
      axi_write(A_DRV, 8'h01 << i, 4'h1, `CDS_RESP_OKAY);
      chk("drive bit", drive_bits, 32'h1 << i);
      rd_chk(A_DRV, 8'h01 << i, `CDS_RESP_OKAY);
      axi_write(A_DISC, 8'h01 << i, 4'h1, `CDS_RESP_OKAY);
      chk("disc bit", disc_bits, 32'h1 << i);
    end
    axi_write(A_DISC, 8'hff, 4'h1, `CDS_RESP_OKAY);
    rd_chk(A_DISC, 8'h3f, `CDS_RESP_OKAY);
    chk("disc all", disc_bits, 32'h3f);
  endtask

  task automatic t_timing();
    int gap;
    logic [1:0] code [3];
    int divs [3];
    code = '{2'h0, 2'h2, 2'h3};
    divs = '{16, 2, 4};
    axi_write(A_CFG, 8'h00, 4'h1, `CDS_RESP_OKAY);
    tick_gap(1'b0, gap);
    chk("mod gap 4", gap, 32'd4);
    for (int i = 0; i < 3; i++) begin
      axi_write(A_DRV, {code[i], 6'h0}, 4'h1, `CDS_RESP_OKAY);
      rd_chk(A_DRV, {code[i], 6'h0}, `CDS_RESP_OKAY);
      tick_gap(1'b1, gap);
      chk("chop gap", gap, divs[i] * 4);
    end
    axi_write(A_CFG, 8'hff, 4'h1, `CDS_RESP_OKAY);
    rd_chk(A_CFG, 8'h01, `CDS_RESP_OKAY);
    chk("div select", div_sel, 32'h1);
    tick_gap(1'b0, gap);
    chk("mod gap 16", gap, 32'd16);
    axi_write(A_DRV, 8'h80, 4'h1, `CDS_RESP_OKAY);
    tick_gap(1'b1, gap);
    chk("chop gap slow", gap, 32'd32);
    axi_write(A_DRV, 8'h40, 4'h1, `CDS_RESP_OKAY);
    gap = 0;
    repeat (300) begin
      @(posedge clk);
      if (chop_tick === 1'b1) gap++;
    end
    chk("reserved chop", gap, 32'd0);
    // status: powered down on shorted input, gain 8, chop code reserved
    rd_chk(A_STAT, 8'h28, `CDS_RESP_OKAY);
    // reserved source while powered down raises both flags
    axi_write(A_CH2, 8'h8a, 4'h1, `CDS_RESP_OKAY);
    rd_chk(A_STAT, 8'hb6, `CDS_RESP_OKAY);
  endtask

  task automatic t_bus();
    axi_write(A_DISC, 8'h05, 4'h1, `CDS_RESP_OKAY);
    axi_write(A_DISC, 8'h0a, 4'h0, `CDS_RESP_OKAY);
    rd_chk(A_DISC, 8'h05, `CDS_RESP_OKAY);
    axi_write(8'h20, 8'h11, 4'h1, `CDS_RESP_SLVERR);
    rd_chk(8'h20, 8'h00, `CDS_RESP_SLVERR);
    axi_write(A_STAT, 8'hff, 4'h1, `CDS_RESP_OKAY);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk(A_DISC, 8'h00, `CDS_RESP_OKAY);
    rd_chk(A_CH2, 8'h00, `CDS_RESP_OKAY);
    chk("gain after reset", gain_value, 32'h6);
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_settings();
    t_walk();
    t_timing();
    t_bus();
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
